/* File: tb_timer16_waveform_mode_control.sv */
// Self-checking bench: measures pin A duty per waveform and output mode.
// Assumes tmwm_timer with a pull-up pin model on both compare pins.
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_waveform_mode_control;
  import tmwm_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] dir = 2'b00;
  logic [1:0] pdata = 2'b00;
  logic ext_pin = 1'b0;
  logic [1:0] pout, poe, lvl;
  logic irq;
  logic [15:0] lf = 16'h0032;
  int fails = 0;
  int tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  tmwm_timer i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(ext_pin), .capture_pin(1'b0), .port_dir_out(dir),
    .port_data(pdata), .compare_pin_out(pout), .compare_pin_oe(poe), .compare_pin_sel(), .irq(irq));
  tmwm_pin_model i_pins (.pin_out(pout), .pin_oe(poe), .pin_level(lvl));
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // Answer stands until the next edge; take it there
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  // High byte goes to the shared temp first, low byte commits both
  task automatic w16(logic [3:0] a, logic [15:0] v);
    wr(4'(a + 1), v[15:8]);
    wr(a, v[7:0]);
  endtask
  // Stop, load compare and TOP, start, let two windows settle, count high cycles
  task automatic run(logic [3:0] wm, logic [1:0] com, logic [2:0] cs, logic [15:0] top, int c, int win, int exp);
    int hi;
    hi = 0;
    wr(TMWM_OFS_CTRL_A, 8'h00);
    wr(TMWM_OFS_CTRL_B, 8'h00);
    w16(TMWM_OFS_CMP_A_LO, 16'(c));
    w16(TMWM_OFS_CAP_LO, top);
    w16(TMWM_OFS_CNT_LO, 16'h0000);
    wr(TMWM_OFS_CTRL_B, {3'b000, wm[3:2], cs});
    wr(TMWM_OFS_CTRL_A, {com, 4'h0, wm[1:0]});
    repeat (2 * win) @(posedge clk_sys);
    repeat (win) begin
      @(negedge clk_sys);
      if (lvl[0] === 1'b1) hi++;
    end
    @(posedge clk_sys);
    check(16'(hi), 16'(exp));
    $display("mode %0d output mode %0d done", wm, com);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  initial begin
    int c8, c6, div;
    logic [7:0] d;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    dir <= 2'b11;
    pdata <= lf[1:0];
    rd(TMWM_OFS_CTRL_A, d);
    check(16'(d), 16'h0000);
    check(16'(pout), 16'(lf[1:0]));
    wr(TMWM_OFS_CTRL_A, 8'hff);
    rd(TMWM_OFS_CTRL_A, d);
    check(16'(d), 16'h00f3);
    check(16'(lvl), 16'h0000);
    wr(TMWM_OFS_CTRL_B, 8'hff);
    rd(TMWM_OFS_CTRL_B, d);
    check(16'(d), 16'h001f);
    rd(4'hc, d);
    check(16'(d), 16'h0000);
    pdata <= 2'b00;
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      c8 = int'(lf[7:0]);
      c6 = int'(lf[12:8]) | 1;
      run(4'd5, 2'b10, 3'd1, 16'h00ff, c8, 256, c8 + 1);
      run(4'd7, 2'b11, 3'd1, 16'h00ff, c8, 1024, 1023 - c8);
      run(4'd2, 2'b10, 3'd1, 16'h00ff, c8, 1022, 2 * c8);
      run(4'd1, 2'b11, 3'd1, 16'h00ff, c8, 510, 510 - 2 * c8);
      run(4'd8, 2'b10, 3'd1, 16'h003f, c6, 126, 2 * c6);
      run(4'd10, 2'b11, 3'd1, 16'h003f, c6, 126, 126 - 2 * c6);
      run(4'd14, 2'b10, 3'd1, 16'h003f, c6, 64, c6 + 1);
      run(4'd14, 2'b01, 3'd1, 16'h003f, c6, 128, 64);
      run(4'd5, 2'b01, 3'd1, 16'h003f, c6, 256, 0);
      run(4'd4, 2'b01, 3'd1, 16'h003f, c6, 2 * c6 + 2, c6 + 1);
      for (int m = 1; m < 4; m++) run(4'd12, 2'(m), 3'd1, 16'h003f, c6, 128, m == 1 ? 64 : (m == 3 ? 128 : 0));
    end
    for (int s = 2; s < 6; s++) begin
      div = s == 2 ? 8 : (s == 3 ? 64 : (s == 4 ? 256 : 1024));
      run(4'd14, 2'b10, 3'(s), 16'h0003, int'(lf[1:0]), 4 * div, div * (int'(lf[1:0]) + 1));
    end
    // Pin edge sources: count pulses on the external pin in normal mode
    wr(TMWM_OFS_CTRL_A, 8'h00);
    for (int s = 6; s < 8; s++) begin
      wr(TMWM_OFS_CTRL_B, {5'h00, 3'(s)});
      w16(TMWM_OFS_CNT_LO, 16'h0000);
      repeat (int'(lf[7:4]) + 1) begin
        ext_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
      end
      rd(TMWM_OFS_CNT_LO, d);
      check(16'(d), 16'(int'(lf[7:4]) + 1));
      $display("pin edge source %0d done", s);
    end
    run(4'd5, 2'b11, 3'd1, 16'h00ff, 255, 256, 0);
    run(4'd5, 2'b10, 3'd1, 16'h00ff, 255, 256, 256);
    wr(TMWM_OFS_IRQ_MASK, 8'h01);
    repeat (300) @(posedge clk_sys);
    @(negedge clk_sys);
    check(16'(irq), 16'h0001);
    @(posedge clk_sys);
    wr(TMWM_OFS_CTRL_B, 8'h00);
    wr(TMWM_OFS_IRQ_MASK, 8'h00);
    @(negedge clk_sys);
    check(16'(irq), 16'h0000);
    @(posedge clk_sys);
    rd(TMWM_OFS_IRQ_STAT, d);
    check(16'(d[0]), 16'h0001);
    wr(TMWM_OFS_IRQ_STAT, 8'h07);
    wr(TMWM_OFS_IRQ_MASK, 8'h07);
    rd(TMWM_OFS_IRQ_STAT, d);
    check(16'(d), 16'h0000);
    @(negedge clk_sys);
    check(16'(irq), 16'h0000);
    @(posedge clk_sys);
    dir <= 2'b00;
    repeat (2) @(negedge clk_sys);
    check(16'(lvl), 16'h0003);
    test_done();
  end
endmodule // tb_timer16_waveform_mode_control
`default_nettype wire

/* File: tmwm_pin_model.sv */
// Board side of the two compare pins: output drivers and a pull-up.
// Assumes the pin is released whenever its output enable is low.
`timescale 1ns/1ps
`default_nettype none
module tmwm_pin_model (
  // Design side
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // Board side
  output logic [1:0] pin_level
);
  // Pull-up keeps a released pin high instead of the last driven level
  assign pin_level = (pin_out & pin_oe) | ~pin_oe;
endmodule // tmwm_pin_model
`default_nettype wire

/* File: tmwm_pkg.sv */
// Package for the 16-bit timer waveform mode and compare output block.
// Assumes a single 40 MHz system clock domain.
`default_nettype none
package tmwm_pkg;
  // Register map (byte addresses)
  localparam logic [3:0] TMWM_OFS_CTRL_A = 4'h0;
  localparam logic [3:0] TMWM_OFS_CTRL_B = 4'h1;
  localparam logic [3:0] TMWM_OFS_CMP_A_LO = 4'h2;
  localparam logic [3:0] TMWM_OFS_CMP_A_HI = 4'h3;
  localparam logic [3:0] TMWM_OFS_CMP_B_LO = 4'h4;
  localparam logic [3:0] TMWM_OFS_CMP_B_HI = 4'h5;
  localparam logic [3:0] TMWM_OFS_CAP_LO = 4'h6;
  localparam logic [3:0] TMWM_OFS_CAP_HI = 4'h7;
  localparam logic [3:0] TMWM_OFS_CNT_LO = 4'h8;
  localparam logic [3:0] TMWM_OFS_CNT_HI = 4'h9;
  localparam logic [3:0] TMWM_OFS_IRQ_STAT = 4'ha;
  localparam logic [3:0] TMWM_OFS_IRQ_MASK = 4'hb;
  // Field positions
  localparam int TMWM_CA_MODE_A_LSB = 6;
  localparam int TMWM_CA_MODE_B_LSB = 4;
  localparam int TMWM_CB_WGM_HI_LSB = 3;
  localparam logic [7:0] TMWM_CTRL_A_RST = 8'h00;
  localparam logic [7:0] TMWM_CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] TMWM_CTRL_B_WMASK = 8'h1f;
  // Status bits: 0 overflow, 1 match A, 2 match B
  localparam int TMWM_IRQ_OVF = 0;
  localparam int TMWM_IRQ_CMA = 1;
  localparam int TMWM_IRQ_CMB = 2;
  // Fixed TOPs and limits
  localparam logic [15:0] TMWM_MAX = 16'hffff;
  localparam logic [15:0] TMWM_TOP8 = 16'h00ff;
  localparam logic [15:0] TMWM_TOP9 = 16'h01ff;
  localparam logic [15:0] TMWM_TOP10 = 16'h03ff;
  localparam logic [15:0] TMWM_BOTTOM = 16'h0000;
  // Prescaler divisions minus one
  localparam logic [9:0] TMWM_DIV8 = 10'h007;
  localparam logic [9:0] TMWM_DIV64 = 10'h03f;
  localparam logic [9:0] TMWM_DIV256 = 10'h0ff;
  localparam logic [9:0] TMWM_DIV1024 = 10'h3ff;

  typedef enum logic [1:0] {TMWM_NONPWM, TMWM_FAST, TMWM_PHASE, TMWM_PFC} tmwm_kind_t;
  typedef enum logic [1:0] {TMWM_UPD_NOW, TMWM_UPD_TOP, TMWM_UPD_BOT} tmwm_upd_t;
  typedef enum logic [1:0] {TMWM_OVF_MAX, TMWM_OVF_TOP, TMWM_OVF_BOT} tmwm_ovf_t;

  typedef struct packed {
    tmwm_kind_t kind;
    tmwm_upd_t upd;
    tmwm_ovf_t ovf;
    logic [15:0] top;
  } tmwm_decode_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic down;
    logic [7:0] hi_tmp;
    logic [9:0] pre;
    logic [2:0] ext_sync;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [7:0] rdata;
    logic [1:0] oc;
    logic [1:0] pin_oe;
    logic [1:0] pin_out;
    logic [1:0] pin_sel;
    logic irq;
  } tmwm_state_t;
endpackage : tmwm_pkg
`default_nettype wire

/* File: tmwm_timer.sv */
// Mode decode, counter, double buffers and compare outputs of a 16-bit timer.
// Assumes an 8-bit register port on clk_sys and pins synchronised here.
//
// Operation
// - Synchronous to clk_sys; counter, status flags and compare outputs advance only on timer tick cycles.
// - BOTTOM-based load and overflow mirror TOP timing using BOTTOM, BOTTOM+1.
// - Control A: mode A 7:6, mode B 5:4, wave low 1:0, 3:2 zero.
// - Nonzero output mode routes compare output to the pin instead of port, except PWM 01 unless A toggles.
// - Pin driver enabled only when direction bit selects output.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at TOP; 11 the reverse.
// - PWM with 01: off if wave MSB 0; else A toggles, B reserved.
// - Fast PWM, compare equals TOP, mode high bit: only TOP action.
// - Dual slope: 10 clears on up match, sets on down; 11 opposite.
// - Wave mode is control B bits 4:3 joined to control A bits 1:0.
// - Modes 0, 4, 12: up count, immediate load, overflow at MAX; 13 reserved.
// - Modes 1-3, 10, 11: phase correct, load at TOP, overflow at BOTTOM.
// - Modes 5-7, 14, 15: fast PWM, load at TOP, overflow at TOP.
// - Modes 8, 9: phase-frequency correct, load and overflow at BOTTOM.
// - Wave mode high bits sit at control B bits 4:3.
// - Three-bit tick source: stop, /1, /8, /64, /256, /1024, pin edges.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tmwm_timer
  import tmwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins and port logic
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic [1:0] port_dir_out,
  input wire logic [1:0] port_data,
  output logic [1:0] compare_pin_out,
  output logic [1:0] compare_pin_oe,
  output logic [1:0] compare_pin_sel,
  // Interrupt
  output logic irq
);
  tmwm_state_t s_q;
  tmwm_state_t s_d;
  tmwm_decode_t dec;
  logic [3:0] waveform_mode;
  logic tick;
  logic [15:0] next_cnt;
  logic at_top;
  logic at_bot;
  logic [1:0] match;
  logic [1:0] chan_output_mode [2];
  logic ovf_ev;
  logic load_now;
  logic [2:0] stat_set;

  assign waveform_mode = {s_q.ctrl_b[TMWM_CB_WGM_HI_LSB +: 2], s_q.ctrl_a[1:0]};
  assign chan_output_mode[0] = s_q.ctrl_a[TMWM_CA_MODE_A_LSB +: 2];
  assign chan_output_mode[1] = s_q.ctrl_a[TMWM_CA_MODE_B_LSB +: 2];

  always_comb begin
    dec = '{kind: TMWM_NONPWM, upd: TMWM_UPD_NOW, ovf: TMWM_OVF_MAX, top: TMWM_MAX};
    case (waveform_mode)
      4'h0: dec.top = TMWM_MAX;
      4'h1: dec = '{TMWM_PHASE, TMWM_UPD_TOP, TMWM_OVF_BOT, TMWM_TOP8};
      4'h2: dec = '{TMWM_PHASE, TMWM_UPD_TOP, TMWM_OVF_BOT, TMWM_TOP9};
      4'h3: dec = '{TMWM_PHASE, TMWM_UPD_TOP, TMWM_OVF_BOT, TMWM_TOP10};
      4'h4: dec.top = s_q.cmp_a;
      4'h5: dec = '{TMWM_FAST, TMWM_UPD_TOP, TMWM_OVF_TOP, TMWM_TOP8};
      4'h6: dec = '{TMWM_FAST, TMWM_UPD_TOP, TMWM_OVF_TOP, TMWM_TOP9};
      4'h7: dec = '{TMWM_FAST, TMWM_UPD_TOP, TMWM_OVF_TOP, TMWM_TOP10};
      4'h8: dec = '{TMWM_PFC, TMWM_UPD_BOT, TMWM_OVF_BOT, s_q.cap};
      4'h9: dec = '{TMWM_PFC, TMWM_UPD_BOT, TMWM_OVF_BOT, s_q.cmp_a};
      4'ha: dec = '{TMWM_PHASE, TMWM_UPD_TOP, TMWM_OVF_BOT, s_q.cap};
      4'hb: dec = '{TMWM_PHASE, TMWM_UPD_TOP, TMWM_OVF_BOT, s_q.cmp_a};
      4'hc: dec.top = s_q.cap;
      // Reserved mode behaves as normal counting
      4'hd: dec.top = TMWM_MAX;
      4'he: dec = '{TMWM_FAST, TMWM_UPD_TOP, TMWM_OVF_TOP, s_q.cap};
      4'hf: dec = '{TMWM_FAST, TMWM_UPD_TOP, TMWM_OVF_TOP, s_q.cmp_a};
      default: dec.top = TMWM_MAX;
    endcase
  end

  always_comb begin
    case (s_q.ctrl_b[2:0])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (s_q.pre[2:0] == TMWM_DIV8[2:0]);
      3'h3: tick = (s_q.pre[5:0] == TMWM_DIV64[5:0]);
      3'h4: tick = (s_q.pre[7:0] == TMWM_DIV256[7:0]);
      3'h5: tick = (s_q.pre == TMWM_DIV1024);
      3'h6: tick = s_q.ext_sync[2] & ~s_q.ext_sync[1];
      3'h7: tick = ~s_q.ext_sync[2] & s_q.ext_sync[1];
      default: tick = 1'b0;
    endcase
  end

  assign at_top = (s_q.cnt == dec.top);
  assign at_bot = (s_q.cnt == TMWM_BOTTOM);
  assign match[0] = (s_q.cnt == s_q.cmp_a);
  assign match[1] = (s_q.cnt == s_q.cmp_b);

  // Counter sequence
  always_comb begin
    next_cnt = s_q.cnt + 16'h0001;
    if (dec.kind == TMWM_PHASE || dec.kind == TMWM_PFC) begin
      if (s_q.down) begin
        next_cnt = at_bot ? 16'h0001 : s_q.cnt - 16'h0001;
      end else if (at_top) begin
        next_cnt = s_q.cnt - 16'h0001;
      end
    end else if (at_top) begin
      next_cnt = TMWM_BOTTOM;
    end
  end

  always_comb begin
    case (dec.ovf)
      TMWM_OVF_MAX: ovf_ev = (s_q.cnt == TMWM_MAX);
      TMWM_OVF_TOP: ovf_ev = at_top;
      TMWM_OVF_BOT: ovf_ev = at_bot && s_q.down;
      default: ovf_ev = 1'b0;
    endcase
  end
  assign load_now = (dec.upd == TMWM_UPD_NOW);
  // Events of this cycle; a same-cycle software clear cannot undo them
  assign stat_set = {match[1], match[0], ovf_ev} & {3{tick}};

  always_comb begin
    s_d = s_q;
    s_d.pre = s_q.pre + 10'h001;
    // Two stages before the edge detector reads the pin
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_count_pin};
    s_d.rdata = 8'h00;
    if (tick) begin
      s_d.cnt = next_cnt;
      if (dec.kind == TMWM_PHASE || dec.kind == TMWM_PFC) begin
        if (at_top) s_d.down = 1'b1;
        else if (at_bot) s_d.down = 1'b0;
      end else begin
        s_d.down = 1'b0;
      end
      if ((dec.upd == TMWM_UPD_TOP && at_top) || (dec.upd == TMWM_UPD_BOT && at_bot && s_q.down)) begin
        s_d.cmp_a = s_q.cmp_a_buf;
        s_d.cmp_b = s_q.cmp_b_buf;
      end
      if (ovf_ev) s_d.stat[TMWM_IRQ_OVF] = 1'b1;
      if (match[0]) s_d.stat[TMWM_IRQ_CMA] = 1'b1;
      if (match[1]) s_d.stat[TMWM_IRQ_CMB] = 1'b1;
      for (int c = 0; c < 2; c++) begin
        case (dec.kind)
          TMWM_NONPWM: begin
            if (match[c]) begin
              case (chan_output_mode[c])
                2'h1: s_d.oc[c] = ~s_q.oc[c];
                2'h2: s_d.oc[c] = 1'b0;
                2'h3: s_d.oc[c] = 1'b1;
                default: s_d.oc[c] = s_q.oc[c];
              endcase
            end
          end
          TMWM_FAST: begin
            if (chan_output_mode[c][1] && at_top) begin
              s_d.oc[c] = ~chan_output_mode[c][0];
            end else if (match[c]) begin
              if (chan_output_mode[c][1]) s_d.oc[c] = chan_output_mode[c][0];
              // toggle only A with MSB set
              else if (chan_output_mode[c][0] && waveform_mode[3] && c == 0) s_d.oc[c] = ~s_q.oc[c];
            end
          end
          default: begin
            if (match[c]) begin
              if (chan_output_mode[c][1]) s_d.oc[c] = chan_output_mode[c][0] ^ s_q.down;
              // toggle only A with MSB set
              else if (chan_output_mode[c][0] && waveform_mode[3] && c == 0) s_d.oc[c] = ~s_q.oc[c];
            end
          end
        endcase
      end
    end
    // Capture is loaded by software only; the capture pin is not sampled
    if (reg_wr) begin
      case (reg_addr)
        TMWM_OFS_CTRL_A: s_d.ctrl_a = reg_wdata & TMWM_CTRL_A_WMASK;
        TMWM_OFS_CTRL_B: s_d.ctrl_b = reg_wdata & TMWM_CTRL_B_WMASK;
        TMWM_OFS_CMP_A_HI, TMWM_OFS_CMP_B_HI, TMWM_OFS_CAP_HI, TMWM_OFS_CNT_HI: s_d.hi_tmp = reg_wdata;
        TMWM_OFS_CMP_A_LO: begin
          s_d.cmp_a_buf = {s_q.hi_tmp, reg_wdata};
          if (load_now) s_d.cmp_a = {s_q.hi_tmp, reg_wdata};
        end
        TMWM_OFS_CMP_B_LO: begin
          s_d.cmp_b_buf = {s_q.hi_tmp, reg_wdata};
          if (load_now) s_d.cmp_b = {s_q.hi_tmp, reg_wdata};
        end
        TMWM_OFS_CAP_LO: s_d.cap = {s_q.hi_tmp, reg_wdata};
        TMWM_OFS_CNT_LO: s_d.cnt = {s_q.hi_tmp, reg_wdata};
        // Hardware set beats a same-cycle clear
        TMWM_OFS_IRQ_STAT: s_d.stat = (s_q.stat & ~reg_wdata[2:0]) | stat_set;
        TMWM_OFS_IRQ_MASK: s_d.mask = reg_wdata[2:0];
        default: s_d.hi_tmp = s_q.hi_tmp;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        TMWM_OFS_CTRL_A: s_d.rdata = s_q.ctrl_a;
        TMWM_OFS_CTRL_B: s_d.rdata = s_q.ctrl_b;
        TMWM_OFS_CMP_A_LO: s_d.rdata = s_q.cmp_a_buf[7:0];
        TMWM_OFS_CMP_A_HI: s_d.rdata = s_q.cmp_a_buf[15:8];
        TMWM_OFS_CMP_B_LO: s_d.rdata = s_q.cmp_b_buf[7:0];
        TMWM_OFS_CMP_B_HI: s_d.rdata = s_q.cmp_b_buf[15:8];
        TMWM_OFS_CAP_LO: s_d.rdata = s_q.cap[7:0];
        TMWM_OFS_CAP_HI: s_d.rdata = s_q.cap[15:8];
        TMWM_OFS_CNT_LO: s_d.rdata = s_q.cnt[7:0];
        TMWM_OFS_CNT_HI: s_d.rdata = s_q.cnt[15:8];
        TMWM_OFS_IRQ_STAT: s_d.rdata = {5'h00, s_q.stat};
        TMWM_OFS_IRQ_MASK: s_d.rdata = {5'h00, s_q.mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      s_d.pin_sel[c] = (chan_output_mode[c] != 2'h0);
      if (dec.kind != TMWM_NONPWM && chan_output_mode[c] == 2'h1 && !(waveform_mode[3] && c == 0)) begin
        s_d.pin_sel[c] = 1'b0;
      end
      s_d.pin_out[c] = s_d.pin_sel[c] ? s_q.oc[c] : port_data[c];
      s_d.pin_oe[c] = port_dir_out[c];
    end
    s_d.irq = |(s_q.stat & s_q.mask);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign compare_pin_out = s_q.pin_out;
  assign compare_pin_oe = s_q.pin_oe;
  assign compare_pin_sel = s_q.pin_sel;
  assign irq = s_q.irq;
  logic unused_cap_pin;
  assign unused_cap_pin = capture_pin;
endmodule // tmwm_timer
`default_nettype wire

/* File: tmwm_timer_properties.sv */
// Assertions on the register port, pin outputs and interrupt of the timer.
// Assumes binding onto tmwm_timer; mode A and mask are shadowed from writes.
`timescale 1ns/1ps
`default_nettype none
module tmwm_timer_properties
  import tmwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and interrupt
  input wire logic [1:0] port_dir_out,
  input wire logic [1:0] port_data,
  input wire logic [1:0] compare_pin_out,
  input wire logic [1:0] compare_pin_oe,
  input wire logic [1:0] compare_pin_sel,
  input wire logic irq
);
  logic [1:0] mode_a_q;
  logic [2:0] mask_q;
  default clocking
    @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_a_q <= 2'b00;
      mask_q <= 3'b000;
    end else if (reg_wr && reg_addr == TMWM_OFS_CTRL_A) begin
      mode_a_q <= reg_wdata[7:6];
    end else if (reg_wr && reg_addr == TMWM_OFS_IRQ_MASK) begin
      mask_q <= reg_wdata[2:0];
    end
  end
  property p_ctrl_a_rb;
    reg_wr && reg_addr == TMWM_OFS_CTRL_A ##1 !reg_wr ##1 reg_rd && reg_addr == TMWM_OFS_CTRL_A
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'hf3);
  endproperty
  a_ctrl_a_rb: assert property (p_ctrl_a_rb)
    else $error("control A readback wrong");
  property p_ctrl_b_rb;
    reg_wr && reg_addr == TMWM_OFS_CTRL_B ##1 !reg_wr ##1 reg_rd && reg_addr == TMWM_OFS_CTRL_B
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1f);
  endproperty
  a_ctrl_b_rb: assert property (p_ctrl_b_rb)
    else $error("control B readback wrong");
  property p_ctrl_a_rsv;
    reg_rd && reg_addr == TMWM_OFS_CTRL_A |=> reg_rdata[3:2] == 2'b00;
  endproperty
  a_ctrl_a_rsv: assert property (p_ctrl_a_rsv)
    else $error("control A bits 3:2 not zero");
  property p_sel_off;
    mode_a_q == 2'b00 |=> !compare_pin_sel[0];
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("pin A taken while output mode is 00");
  property p_sel_on;
    mode_a_q[1] |=> compare_pin_sel[0];
  endproperty
  a_sel_on: assert property (p_sel_on)
    else $error("pin A not taken by compare output");
  property p_port;
    $past(nrst) && !compare_pin_sel[0] |-> compare_pin_out[0] == $past(port_data[0]);
  endproperty
  a_port: assert property (p_port)
    else $error("port value lost on pin A");
  property p_oe;
    $past(nrst) |-> compare_pin_oe == $past(port_dir_out);
  endproperty
  a_oe: assert property (p_oe)
    else $error("driver enable does not follow direction");
  property p_irq_mask;
    mask_q == 3'b000 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised while fully masked");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");
endmodule // tmwm_timer_properties
bind tmwm_timer tmwm_timer_properties i_props (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_dir_out(port_dir_out),
  .port_data(port_data), .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
  .compare_pin_sel(compare_pin_sel), .irq(irq));
`default_nettype wire
